// [rtl/tls_blinker.sv]
`timescale 1ns/1ps
module tls_blinker import tls_pkg::*; #(
  parameter int W = TIMER_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // control
  input wire logic tick,
  input wire logic start,
  input wire logic [2:0] flashes,
  input wire logic [W-1:0] half_ticks,
  // result
  output logic lamp,
  output logic busy
);

  logic [W-1:0] cnt_reg;
  logic [2:0] left_reg;

  // on half, off half, repeated for the flash count
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lamp <= 1'b0;
      busy <= 1'b0;
      cnt_reg <= '0;
      left_reg <= '0;
    end else if (start) begin
      lamp <= 1'b1;
      busy <= 1'b1;
      cnt_reg <= '0;
      left_reg <= flashes;
    end else if (busy && tick) begin
      if (cnt_reg == half_ticks - W'(1)) begin
        cnt_reg <= '0;
        if (lamp) begin
          lamp <= 1'b0;
          left_reg <= left_reg - 3'h1;
        end else if (left_reg == 3'h0) begin
          busy <= 1'b0;
        end else begin
          lamp <= 1'b1;
        end
      end else begin
        cnt_reg <= cnt_reg + W'(1);
      end
    end
  end

endmodule // tls_blinker

// [rtl/tls_lamp_sequencer.sv]
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module tls_lamp_sequencer import tls_pkg::*; #(
  parameter int TICK_CYCLES_P = TICK_CYCLES,
  parameter int ON_TICKS_P = LAMPS_ON_TICKS,
  parameter int OFF_TICKS_P = LAMPS_OFF_TICKS,
  parameter int CC_DARK_TICKS_P = CC_DARK_TICKS,
  parameter int BLINK_HALF_P = BLINK_HALF_TICKS,
  parameter int GREEN_HALF_P = GREEN_HALF_TICKS
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [DATA_W-1:0] rdata,
  // card state pins
  input wire logic card_disabled_in,
  input wire logic local_alarm_in,
  input wire logic remote_alarm_in,
  input wire logic loopback_in,
  // self-test results from card logic
  input wire logic selftest_partial_fail,
  input wire logic cc_test_pass,
  input wire logic loop_test_complete,
  input wire logic loop_test_fail,
  // card lamps
  output logic card_disabled_lamp,
  output logic card_in_service_lamp,
  output logic local_alarm_lamp,
  output logic remote_alarm_lamp,
  output logic loopback_lamp,
  // daughterboard lamps
  output logic cc_lamp_red,
  output logic cc_lamp_green,
  output logic handler_lamp_red,
  output logic handler_lamp_green,
  // local loopback test control
  output logic loop_test_active,
  output logic loop_test_per_channel,
  output logic [TEST_CHECK_W-1:0] loop_test_checks,
  output logic [TEST_CHAN_W-1:0] loop_test_channel,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int TW = TIMER_W;
  logic [3:0] pins_s;
  logic dis_s, red_s, yel_s, lbk_s;
  logic [DIV_W-1:0] div_reg;
  logic tick_reg;
  tls_card_seq_e card_state_reg;
  tls_cc_seq_e cc_state_reg;
  logic [TW-1:0] card_timer_reg, cc_timer_reg, green_timer_reg;
  logic green_phase_reg;
  logic card_blink_start, card_blink_lamp, card_busy;
  logic cc_blink_start, cc_blink_lamp, cc_busy;
  logic [2:0] card_flash_target;
  logic [2:0] card_flash_reg;
  logic cc_en_reg, handler_en_reg, green_blink_reg;
  logic loop_test_fail_reg;
  logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_set;
  logic test_write, test_accept, post_done_pulse;

  // ----------------------------------------------------------------
  // pin synchronisers and tick divider
  // ----------------------------------------------------------------
  tls_sync #(.W(4)) u_sync (
    .clock(clock),
    .resetn(resetn),
    .async_in({card_disabled_in, local_alarm_in, remote_alarm_in, loopback_in}),
    .sync_out(pins_s)
  );
  assign {dis_s, red_s, yel_s, lbk_s} = pins_s;

  // one-cycle tick every millisecond
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == DIV_W'(TICK_CYCLES_P - 1)) begin
      div_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + DIV_W'(1);
      tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // card lamp power-on sequence
  // ----------------------------------------------------------------
  assign card_flash_target = selftest_partial_fail ? PARTIAL_FLASHES : PASS_FLASHES;
  assign card_blink_start = (card_state_reg == CARD_ALL_OFF) && tick_reg &&
                            (card_timer_reg == TW'(OFF_TICKS_P - 1));
  assign post_done_pulse = (card_state_reg == CARD_BLINK) && !card_busy;

  // all on, all off, flash, then live
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      card_state_reg <= CARD_ALL_ON;
      card_timer_reg <= '0;
      card_flash_reg <= PASS_FLASHES;
    end else begin
      unique case (card_state_reg)
        CARD_ALL_ON: begin
          if (tick_reg && card_timer_reg == TW'(ON_TICKS_P - 1)) begin
            card_state_reg <= CARD_ALL_OFF;
            card_timer_reg <= '0;
          end else if (tick_reg) begin
            card_timer_reg <= card_timer_reg + TW'(1);
          end
        end
        CARD_ALL_OFF: begin
          if (card_blink_start) begin
            card_state_reg <= CARD_BLINK;
            card_timer_reg <= '0;
            card_flash_reg <= card_flash_target;
          end else if (tick_reg) begin
            card_timer_reg <= card_timer_reg + TW'(1);
          end
        end
        CARD_BLINK: begin
          if (post_done_pulse) begin
            card_state_reg <= CARD_LIVE;
          end
        end
        CARD_LIVE: begin
          card_state_reg <= CARD_LIVE;
        end
      endcase
    end
  end

  tls_blinker #(.W(TW)) u_card_blink (
    .clock(clock),
    .resetn(resetn),
    .tick(tick_reg),
    .start(card_blink_start),
    .flashes(card_flash_target),
    .half_ticks(TW'(BLINK_HALF_P)),
    .lamp(card_blink_lamp),
    .busy(card_busy)
  );

  // five card lamps by sequence phase
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      card_disabled_lamp <= 1'b1;
      card_in_service_lamp <= 1'b1;
      local_alarm_lamp <= 1'b1;
      remote_alarm_lamp <= 1'b1;
      loopback_lamp <= 1'b1;
    end else if (card_state_reg == CARD_LIVE) begin
      card_disabled_lamp <= dis_s;
      card_in_service_lamp <= !dis_s && !red_s && !yel_s && !lbk_s;
      local_alarm_lamp <= red_s;
      remote_alarm_lamp <= yel_s;
      loopback_lamp <= lbk_s;
    end else begin
      card_disabled_lamp <= (card_state_reg == CARD_ALL_ON) || (card_state_reg == CARD_BLINK && card_blink_lamp);
      card_in_service_lamp <= (card_state_reg == CARD_ALL_ON) || (card_state_reg == CARD_BLINK && card_blink_lamp);
      local_alarm_lamp <= (card_state_reg == CARD_ALL_ON) || (card_state_reg == CARD_BLINK && card_blink_lamp);
      remote_alarm_lamp <= (card_state_reg == CARD_ALL_ON) || (card_state_reg == CARD_BLINK && card_blink_lamp);
      loopback_lamp <= (card_state_reg == CARD_ALL_ON) || (card_state_reg == CARD_BLINK && card_blink_lamp);
    end
  end

  // ----------------------------------------------------------------
  // clock controller lamp
  // ----------------------------------------------------------------
  assign cc_blink_start = (cc_state_reg == CC_DARK) && tick_reg && cc_test_pass &&
                          (cc_timer_reg == TW'(CC_DARK_TICKS_P - 1));

  // dark, red flashes, steady red, enabled
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cc_state_reg <= CC_DARK;
      cc_timer_reg <= '0;
    end else begin
      unique case (cc_state_reg)
        CC_DARK: begin
          if (tick_reg && cc_timer_reg == TW'(CC_DARK_TICKS_P - 1)) begin
            cc_state_reg <= cc_test_pass ? CC_BLINK : CC_FAILED;
          end else if (tick_reg) begin
            cc_timer_reg <= cc_timer_reg + TW'(1);
          end
        end
        CC_BLINK: begin
          if (!cc_busy) begin
            cc_state_reg <= CC_RED;
          end
        end
        CC_RED: begin
          if (cc_en_reg) begin
            cc_state_reg <= CC_ENABLED;
          end
        end
        CC_ENABLED: begin
          if (!cc_en_reg) begin
            cc_state_reg <= CC_RED;
          end
        end
        CC_FAILED: begin
          cc_state_reg <= CC_FAILED;
        end
        default: begin
          cc_state_reg <= CC_DARK;
        end
      endcase
    end
  end

  tls_blinker #(.W(TW)) u_cc_blink (
    .clock(clock),
    .resetn(resetn),
    .tick(tick_reg),
    .start(cc_blink_start),
    .flashes(CC_FLASHES),
    .half_ticks(TW'(BLINK_HALF_P)),
    .lamp(cc_blink_lamp),
    .busy(cc_busy)
  );

  // free-running green blink phase
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      green_timer_reg <= '0;
      green_phase_reg <= 1'b1;
    end else if (tick_reg && green_timer_reg == TW'(GREEN_HALF_P - 1)) begin
      green_timer_reg <= '0;
      green_phase_reg <= !green_phase_reg;
    end else if (tick_reg) begin
      green_timer_reg <= green_timer_reg + TW'(1);
    end
  end

  // daughterboard lamp drive
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cc_lamp_red <= 1'b0;
      cc_lamp_green <= 1'b0;
      handler_lamp_red <= 1'b1;
      handler_lamp_green <= 1'b0;
    end else begin
      cc_lamp_red <= (cc_state_reg == CC_RED) || (cc_state_reg == CC_BLINK && cc_blink_lamp);
      cc_lamp_green <= (cc_state_reg == CC_ENABLED) && (!green_blink_reg || green_phase_reg);
      handler_lamp_red <= !handler_en_reg;
      handler_lamp_green <= handler_en_reg;
    end
  end

  // ----------------------------------------------------------------
  // register port and local loopback test
  // ----------------------------------------------------------------
  assign test_write = wr_strobe && addr == ADDR_TEST && wdata[TEST_START];
  assign test_accept = test_write && card_state_reg == CARD_LIVE && !loop_test_active &&
                       (wdata[TEST_PER_CHAN] || (dis_s && !handler_en_reg));

  // control register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cc_en_reg <= 1'b0;
      handler_en_reg <= 1'b0;
      green_blink_reg <= 1'b0;
    end else if (wr_strobe && addr == ADDR_CTRL) begin
      cc_en_reg <= wdata[CTRL_CC_EN];
      handler_en_reg <= wdata[CTRL_HANDLER_EN];
      green_blink_reg <= wdata[CTRL_GREEN_BLINK];
    end
  end

  // loopback test scope and run flag
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      loop_test_active <= 1'b0;
      loop_test_per_channel <= 1'b0;
      loop_test_checks <= '0;
      loop_test_channel <= '0;
      loop_test_fail_reg <= 1'b0;
    end else if (test_accept) begin
      loop_test_active <= 1'b1;
      loop_test_per_channel <= wdata[TEST_PER_CHAN];
      loop_test_checks <= wdata[TEST_CHECK_LSB +: TEST_CHECK_W];
      loop_test_channel <= wdata[TEST_CHAN_LSB +: TEST_CHAN_W];
    end else if (loop_test_active && loop_test_complete) begin
      loop_test_active <= 1'b0;
      loop_test_fail_reg <= loop_test_fail;
    end
  end

  // sticky events, set wins over clear
  assign irq_set = {loop_test_active && loop_test_complete, test_write && !test_accept, post_done_pulse};
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_strobe && addr == ADDR_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~wdata[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      if (wr_strobe && addr == ADDR_IRQ_MASK) begin
        irq_mask_reg <= wdata[IRQ_W-1:0];
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (rd_strobe) begin
      rdata <= '0;
      unique case (addr)
        ADDR_CTRL: begin
          rdata[CTRL_CC_EN] <= cc_en_reg;
          rdata[CTRL_HANDLER_EN] <= handler_en_reg;
          rdata[CTRL_GREEN_BLINK] <= green_blink_reg;
        end
        ADDR_TEST: begin
          rdata[TEST_PER_CHAN] <= loop_test_per_channel;
          rdata[TEST_CHECK_LSB +: TEST_CHECK_W] <= loop_test_checks;
          rdata[TEST_CHAN_LSB +: TEST_CHAN_W] <= loop_test_channel;
        end
        ADDR_STATUS: begin
          rdata[STAT_CARD_LSB +: 2] <= card_state_reg;
          rdata[STAT_CC_LSB +: 3] <= cc_state_reg;
          rdata[STAT_TEST_ACT] <= loop_test_active;
          rdata[STAT_TEST_FAIL] <= loop_test_fail_reg;
        end
        ADDR_IRQ_STAT: rdata[IRQ_W-1:0] <= irq_stat_reg;
        ADDR_IRQ_MASK: rdata[IRQ_W-1:0] <= irq_mask_reg;
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // flashes seen on the card lamp during the blink phase
  logic [2:0] flash_seen_reg;
  logic blink_lamp_d_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flash_seen_reg <= '0;
      blink_lamp_d_reg <= 1'b0;
    end else begin
      blink_lamp_d_reg <= card_blink_lamp;
      if (card_blink_start) begin
        flash_seen_reg <= '0;
      end else if (card_blink_lamp && !blink_lamp_d_reg) begin
        flash_seen_reg <= flash_seen_reg + 3'h1;
      end
    end
  end

  sequence live_steady;
    card_state_reg == CARD_LIVE && $past(card_state_reg) == CARD_LIVE;
  endsequence
  sequence handler_on_write;
    wr_strobe && addr == ADDR_CTRL && wdata[CTRL_HANDLER_EN];
  endsequence
  sequence cc_leaves_dark;
    cc_state_reg == CC_BLINK && $past(cc_state_reg) == CC_DARK;
  endsequence

  disabled_lamp_a: assert property (
    live_steady |-> card_disabled_lamp == $past(dis_s))
    else $error("disabled lamp not following card state");
  in_service_a: assert property (
    live_steady |-> card_in_service_lamp == !($past(dis_s) || $past(red_s) || $past(yel_s) || $past(lbk_s)))
    else $error("in-service lamp wrong");
  alarm_lamps_a: assert property (
    live_steady |-> local_alarm_lamp == $past(red_s) && remote_alarm_lamp == $past(yel_s))
    else $error("alarm lamps wrong");
  loopback_lamp_a: assert property (
    live_steady |-> loopback_lamp == $past(lbk_s))
    else $error("loopback lamp wrong");
  power_on_a: assert property (
    card_state_reg == CARD_ALL_ON |-> card_disabled_lamp && card_in_service_lamp && local_alarm_lamp &&
      remote_alarm_lamp && loopback_lamp)
    else $error("lamps not all on at power-up");
  all_off_a: assert property (
    card_state_reg == CARD_ALL_OFF && $past(card_state_reg) == CARD_ALL_OFF |-> !(card_disabled_lamp ||
      card_in_service_lamp || local_alarm_lamp || remote_alarm_lamp || loopback_lamp))
    else $error("lamps not off in test phase");
  flash_count_a: assert property (
    $fell(card_busy) |-> flash_seen_reg == card_flash_reg)
    else $error("wrong number of card flashes");
  cc_dark_a: assert property (
    cc_state_reg == CC_DARK |-> ##1 !cc_lamp_red && !cc_lamp_green)
    else $error("clock controller lamp lit too early");
  cc_flash_red_a: assert property (
    cc_leaves_dark |-> ##1 cc_lamp_red && !cc_lamp_green)
    else $error("clock controller lamp not red after pass");
  cc_steady_red_a: assert property (
    cc_state_reg == CC_RED && $past(cc_state_reg) == CC_RED |-> cc_lamp_red && !cc_lamp_green)
    else $error("clock controller lamp not steady red");
  handler_green_a: assert property (
    handler_on_write |-> ##2 handler_lamp_green && !handler_lamp_red)
    else $error("handler lamp not green after enable");
  test_start_a: assert property (
    test_accept |=> loop_test_active && loop_test_checks == $past(wdata[TEST_CHECK_LSB +: TEST_CHECK_W]))
    else $error("loopback test did not start");

endmodule // tls_lamp_sequencer

// [rtl/tls_pkg.sv]
package tls_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES = CLK_FREQ_HZ / 1_000_000 * TICK_TIME_US;
  localparam int LAMPS_ON_TIME_MS = 11000;
  localparam int LAMPS_OFF_TIME_MS = 1000;
  localparam int CC_DARK_TIME_MS = 2000;
  localparam int BLINK_HALF_TIME_MS = 250;
  localparam int GREEN_HALF_TIME_MS = 500;
  localparam int LAMPS_ON_TICKS = LAMPS_ON_TIME_MS * 1000 / TICK_TIME_US;
  localparam int LAMPS_OFF_TICKS = LAMPS_OFF_TIME_MS * 1000 / TICK_TIME_US;
  localparam int CC_DARK_TICKS = CC_DARK_TIME_MS * 1000 / TICK_TIME_US;
  localparam int BLINK_HALF_TICKS = BLINK_HALF_TIME_MS * 1000 / TICK_TIME_US;
  localparam int GREEN_HALF_TICKS = GREEN_HALF_TIME_MS * 1000 / TICK_TIME_US;
  localparam int TIMER_W = 16;
  localparam int DIV_W = 16;

  // ----------------------------------------------------------------
  // flash counts
  // ----------------------------------------------------------------
  localparam logic [2:0] PASS_FLASHES = 3'h3;
  localparam logic [2:0] PARTIAL_FLASHES = 3'h5;
  localparam logic [2:0] CC_FLASHES = 3'h2;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TEST = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam int CTRL_CC_EN = 0;
  localparam int CTRL_HANDLER_EN = 1;
  localparam int CTRL_GREEN_BLINK = 2;
  localparam int TEST_START = 0;
  localparam int TEST_PER_CHAN = 1;
  localparam int TEST_CHECK_LSB = 4;
  localparam int TEST_CHECK_W = 4;
  localparam int TEST_CHAN_LSB = 8;
  localparam int TEST_CHAN_W = 5;
  localparam int STAT_CARD_LSB = 0;
  localparam int STAT_CC_LSB = 2;
  localparam int STAT_TEST_ACT = 5;
  localparam int STAT_TEST_FAIL = 6;
  localparam int IRQ_POST_DONE = 0;
  localparam int IRQ_TEST_REFUSED = 1;
  localparam int IRQ_TEST_DONE = 2;
  localparam int IRQ_W = 3;

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CARD_ALL_ON = 2'h0,
    CARD_ALL_OFF = 2'h1,
    CARD_BLINK = 2'h3,
    CARD_LIVE = 2'h2
  } tls_card_seq_e;

  typedef enum logic [2:0] {
    CC_DARK = 3'h0,
    CC_BLINK = 3'h1,
    CC_RED = 3'h3,
    CC_ENABLED = 3'h2,
    CC_FAILED = 3'h6
  } tls_cc_seq_e;

endpackage

// [rtl/tls_sync.sv]
`timescale 1ns/1ps
module tls_sync import tls_pkg::*; #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // two flops, first one read only by the second
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // tls_sync

// [tb/test_trunk_card_led_selftest_sequencer.sv]
`timescale 1ns/1ps
module test_trunk_card_led_selftest_sequencer;
  import tls_pkg::*;
  logic clock = 1'b0, resetn = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, d, r;
  logic dis_in = 1'b0, la_in = 1'b0, ra_in = 1'b0, lb_in = 1'b0, pf = 1'b0, fail_in = 1'b0, cc_pass = 1'b1;
  logic cmp, lfail, act, perch, irq, ccr, ccg, hr, hg;
  logic [4:0] lamps, chan;
  logic [3:0] cks, dly = 4'h1;
  int fails = 0, num_checks = 0, n_blink = 0, n_cc = 0, n_g = 0, cyc = 0, seed = 32'hd82b;
  // ------------------------------------------------
  // clock, timeout, flash counters
  // ------------------------------------------------
  initial forever #25 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 7000) begin // tests need about 4600 cycles
      fails++;
      tally_and_finish();
    end
  end
  always @(posedge lamps[0]) n_blink++;
  always @(posedge ccr) n_cc++;
  always @(ccg) n_g++;
  // green blink half period left at its real length: 500 ticks of 4 cycles
  tls_lamp_sequencer #(.TICK_CYCLES_P(4), .ON_TICKS_P(5), .OFF_TICKS_P(3), .CC_DARK_TICKS_P(3),
    .BLINK_HALF_P(2)) i_dut (.clock(clock), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
    .card_disabled_in(dis_in), .local_alarm_in(la_in), .remote_alarm_in(ra_in), .loopback_in(lb_in),
    .selftest_partial_fail(pf), .cc_test_pass(cc_pass), .loop_test_complete(cmp), .loop_test_fail(lfail),
    .card_disabled_lamp(lamps[4]), .card_in_service_lamp(lamps[3]), .local_alarm_lamp(lamps[2]),
    .remote_alarm_lamp(lamps[1]), .loopback_lamp(lamps[0]), .cc_lamp_red(ccr), .cc_lamp_green(ccg),
    .handler_lamp_red(hr), .handler_lamp_green(hg), .loop_test_active(act),
    .loop_test_per_channel(perch), .loop_test_checks(cks), .loop_test_channel(chan), .irq(irq));
  tls_far_side i_far (.clock(clock), .resetn(resetn), .active(act), .delay(dly), .fail_in(fail_in),
    .complete(cmp), .fail(lfail));
  // ------------------------------------------------
  // tasks and expectations
  // ------------------------------------------------
  function automatic logic [4:0] exp_lamps(input logic [3:0] s);
    return {s[3], ~|s, s[2], s[1], s[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a; wdata <= v; wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a; rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    @(negedge clock);
    v = rdata;
  endtask
  task automatic post(input logic p, input logic c);
    @(posedge clock);
    pf <= p;
    cc_pass <= c;
    resetn <= 1'b0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1; n_blink = 0; n_cc = 0;
    repeat (10) @(posedge clock);
    chk("all_on", 32'h1f, lamps);
    chk("cc_dark", 32'h0, ccr);
    chk("handler_red", 32'h1, hr);
    repeat (16) @(posedge clock);
    chk("all_off", 32'h0, lamps);
    repeat (110) @(posedge clock);
    chk("flashes", p ? 32'h5 : 32'h3, n_blink);
    // steady red after the flashes gives one more rising edge; a failed test stays dark
    chk("cc_flashes", c ? 32'(CC_FLASHES) + 32'h1 : 32'h0, n_cc);
    chk("cc_steady", c ? 32'h2 : 32'h0, {ccr, ccg});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    post(1'b0, 1'b0);
    post(1'b1, 1'b1);
    for (int i = 0; i < 24; i++) begin
      d = $random(seed);
      {dis_in, la_in, ra_in, lb_in} <= d[3:0];
      repeat (5) @(posedge clock);
      chk("live_lamps", exp_lamps(d[3:0]), lamps);
    end
    wr(ADDR_CTRL, 32'h3);
    repeat (3) @(posedge clock);
    chk("cc_green", 32'h1, {ccr, ccg});
    chk("handler_green", 32'h1, {hr, hg});
    // blink bit: green toggles every 2000 cycles, so 4100 cycles see two changes
    wr(ADDR_CTRL, 32'h7);
    n_g = 0;
    repeat (4100) @(posedge clock);
    chk("cc_green_blink", 32'h1, 32'(n_g >= 2));
    rd(8'h20, d);
    chk("unmapped", 32'h0, d);
    wr(ADDR_IRQ_MASK, 32'h7);
    wr(ADDR_IRQ_STAT, 32'h7);
    dis_in <= 1'b0;
    wr(ADDR_TEST, 32'h1);
    rd(ADDR_IRQ_STAT, d);
    chk("refused", 32'h2, d);
    chk("no_start", 32'h0, act);
    wr(ADDR_CTRL, 32'h1);
    dis_in <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_IRQ_STAT, 32'h7);
      d = $random(seed);
      fail_in <= d[20]; dly <= i ? 4'hc : 4'h1;
      wr(ADDR_TEST, {19'h0, d[12:4], 2'h0, 1'(i), 1'b1});
      @(negedge clock);
      chk("scope", {d[12:4], 1'(i), 1'b1}, {chan, cks, perch, act});
      repeat (30) @(posedge clock);
      rd(ADDR_STATUS, r);
      chk("test_fail", 32'(d[20]), {31'h0, r[STAT_TEST_FAIL]});
      chk("test_idle", 32'h0, {31'h0, act});
      rd(ADDR_IRQ_STAT, r);
      chk("test_done", 32'h4, r);
      chk("irq", 32'h1, {31'h0, irq});
    end
    tally_and_finish();
  end
endmodule // test_trunk_card_led_selftest_sequencer

// [tb/tls_far_side.sv]
`timescale 1ns/1ps
// ------------------------------------------------
// card datapath answering the loopback test
// ------------------------------------------------
module tls_far_side (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // test handshake
  input wire logic active,
  input wire logic [3:0] delay,
  input wire logic fail_in,
  output logic complete,
  output logic fail
);
  logic [4:0] cnt;
  // one completion pulse, delay + 1 cycles into the test
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt <= 5'h0;
      complete <= 1'b0;
    end else begin
      complete <= active && cnt == {1'b0, delay};
      cnt <= !active ? 5'h0 : (cnt <= {1'b0, delay} ? cnt + 5'h1 : cnt);
    end
  end
  // result only meaningful beside the pulse
  assign fail = complete ? fail_in : ~fail_in;
endmodule // tls_far_side
